// >>> src/dp_core.sv
// Move and arithmetic execution datapath with its register file,
// condition flags, a small data memory and an E clock for peripheral
// transfers. Assumes a single AHB-Lite master and one clock domain.
`timescale 1ns/1ns
module dp_core
  import dp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  output logic             eclk,
  output logic             busy
);

  typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_MULTI, ST_ECLK, ST_DIV} state_t;

  logic [15:0] gpr      [8];
  logic [15:0] next_gpr [8];
  logic [15:0] mem      [MEM_WORDS];
  logic [3:0]  flags;
  logic [3:0]  next_flags;
  state_t      state;
  state_t      next_state;
  op_t         op;
  logic        word;
  logic [2:0]  rd;
  logic [2:0]  rs;
  logic        imm_sel;
  logic [15:0] opnd;
  logic [2:0]  idx;
  logic [2:0]  next_idx;
  logic        a_valid;
  logic        a_write;
  logic [11:0] a_addr;
  logic [3:0]  e_cnt;
  logic        mem_we;
  logic [6:0]  mem_wa;
  logic [15:0] mem_wd;

  // Bus decode
  logic        acc;
  logic        bus_wr;
  logic        wr_cmd;
  logic        wr_opnd;
  logic        wr_flags;
  logic        wr_reg;
  logic        wr_mem;
  logic [11:0] ra;
  logic        ra_reg;
  logic        ra_mem;
  logic [31:0] rd_word;
  logic [12:0] cmd_rb;

  // Operand selection
  logic [15:0] dst;
  logic [15:0] src;
  logic [15:0] src_sx;
  logic [15:0] ea_fp;
  logic [15:0] ea;
  logic [15:0] mword;
  logic [15:0] mdata;
  logic [15:0] store_wd;
  logic [15:0] sp;
  logic [15:0] sp_dec;
  logic [15:0] sp_inc;
  logic [15:0] quick;
  logic [15:0] swapped;
  logic [31:0] prod_w;
  logic [15:0] prod_b;
  logic [2:0]  rp_hi;
  logic [2:0]  rp_lo;
  logic        e_fall;
  logic        div_start;
  logic        div_done;
  logic [15:0] quo;
  logic [15:0] rem;
  logic        div_ovf;
  logic [19:0] alu_add;
  logic [19:0] alu_sub;
  logic [19:0] alu_quick;
  logic [19:0] alu_cmp;
  logic [8:0]  bcd_sum;
  logic [8:0]  bcd_diff;

  // {N, Z} at the operation's size
  function automatic logic [1:0] nz(input logic [15:0] r, input logic wd);
    return wd ? {r[15], r == 16'h0000} : {r[7], r[7:0] == 8'h00};
  endfunction : nz

  // Byte results passed through here leave the upper half of the destination alone
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                        input logic wd);
    return wd ? nw : {old[15:8], nw[7:0]};
  endfunction : merge

  // Returns {N, Z, V, C, result}; carry out is a borrow when subtracting
  function automatic logic [19:0] arith(input logic [15:0] a, input logic [15:0] b,
                                        input logic cin, input logic sub, input logic wd);
    logic [15:0] bb;
    logic [16:0] s;
    logic [8:0]  sb;
    logic [15:0] r;
    logic        v;
    logic        c;
    bb = sub ? ~b : b;
    s  = {1'b0, a} + {1'b0, bb} + {16'h0000, cin ^ sub};
    sb = {1'b0, a[7:0]} + {1'b0, bb[7:0]} + {8'h00, cin ^ sub};
    r  = merge(a, s[15:0], wd);
    r[7:0] = wd ? s[7:0] : sb[7:0];
    c  = (wd ? s[16] : sb[8]) ^ sub;
    v  = wd ? (a[15] == bb[15]) && (r[15] != a[15])
            : (a[7] == bb[7]) && (r[7] != a[7]);
    return {nz(r, wd), v, c, r};
  endfunction : arith

  // Packed BCD byte add, returns {carry, result}
  function automatic logic [8:0] bcd_add(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [4:0] l;
    logic [4:0] h;
    l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    if (l > 5'h09) begin
      l = l + 5'h06;
    end
    h = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, l[4]};
    if (h > 5'h09) begin
      h = h + 5'h06;
    end
    return {h[4], h[3:0], l[3:0]};
  endfunction : bcd_add

  // Packed BCD byte subtract, returns {borrow, result}
  function automatic logic [8:0] bcd_sub(input logic [7:0] a, input logic [7:0] b,
                                         input logic cin);
    logic [4:0] l;
    logic [4:0] h;
    logic       bl;
    logic       bh;
    l  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
    bl = l[4];
    if (bl) begin
      l = l - 5'h06;
    end
    h  = {1'b0, a[7:4]} - {1'b0, b[7:4]} - {4'h0, bl};
    bh = h[4];
    if (bh) begin
      h = h - 5'h06;
    end
    return {bh, h[3:0], l[3:0]};
  endfunction : bcd_sub

  // Zero wait states: the answer is fetched in the address phase
  assign acc      = hsel && htrans[1] && hready;
  assign bus_wr   = a_valid && a_write && (state == ST_IDLE);
  assign wr_cmd   = bus_wr && (a_addr == OFF_CMD);
  assign wr_opnd  = bus_wr && (a_addr == OFF_OPND);
  assign wr_flags = bus_wr && (a_addr == OFF_FLAGS);
  assign wr_reg   = bus_wr && (a_addr[11:5] == OFF_REG[11:5]);
  assign wr_mem   = bus_wr && (a_addr[11:9] == OFF_MEM[11:9]);
  assign ra       = haddr[11:0];
  assign ra_reg   = ra[11:5] == OFF_REG[11:5];
  assign ra_mem   = ra[11:9] == OFF_MEM[11:9];
  assign cmd_rb   = {imm_sel, rs, rd, word, op};
  assign rd_word  = (ra == OFF_CMD)   ? {19'h00000, cmd_rb} :
                    (ra == OFF_OPND)  ? {16'h0000, opnd} :
                    (ra == OFF_FLAGS) ? {28'h0000000, flags} :
                    (ra == OFF_STAT)  ? {31'h00000000, busy} :
                    ra_reg            ? {16'h0000, gpr[ra[4:2]]} :
                    ra_mem            ? {16'h0000, mem[ra[8:2]]} : 32'h00000000;

  // Operand and address formation
  assign dst     = gpr[rd];
  assign src     = imm_sel ? opnd : gpr[rs];
  assign src_sx  = word ? src : {{8{src[7]}}, src[7:0]};
  assign ea_fp   = gpr[REG_FP] + {{8{opnd[7]}}, opnd[7:0]};
  assign ea      = (op == OP_LOAD_FP || op == OP_STORE_FP) ? ea_fp :
                   (op == OP_ECLK_SYNC_WRITE || op == OP_ECLK_SYNC_READ) ? opnd :
                   {8'h00, opnd[7:0]};
  assign mword   = mem[ea[7:1]];
  assign mdata   = word ? mword : {8'h00, ea[0] ? mword[7:0] : mword[15:8]};
  assign store_wd = word ? dst : (ea[0] ? {mword[15:8], dst[7:0]}
                                        : {dst[7:0], mword[7:0]});
  assign sp      = gpr[REG_SP];
  assign sp_dec  = sp - 16'h0002;
  assign sp_inc  = sp + 16'h0002;
  assign quick   = opnd[1] ? (opnd[0] ? 16'hfffe : 16'hffff)
                           : (opnd[0] ? 16'h0002 : 16'h0001);
  assign swapped = {dst[7:0], dst[15:8]};
  assign prod_w  = dst * src;
  assign prod_b  = dst[7:0] * src[7:0];
  assign rp_hi   = {rd[2:1], 1'b0};
  assign rp_lo   = {rd[2:1], 1'b1};
  assign alu_add   = arith(dst, src, flags[FLG_C], 1'b0, word);
  assign alu_sub   = arith(dst, src, flags[FLG_C], 1'b1, word);
  assign alu_quick = arith(dst, quick, 1'b0, 1'b0, word);
  // Compare ignores the incoming carry, unlike subtract with borrow
  assign alu_cmp   = arith(dst, src, 1'b0, 1'b1, word);
  assign bcd_sum   = bcd_add(dst[7:0], src[7:0], flags[FLG_C]);
  assign bcd_diff  = bcd_sub(dst[7:0], src[7:0], flags[FLG_C]);
  assign e_fall    = eclk && (e_cnt == ECLK_HALF - 4'h1);
  assign div_start = (state == ST_RUN) && (op == OP_UNSIGNED_DIVIDE);

  dp_divider u_div (
    .clock     (clock),
    .rst_n     (rst_n),
    .start     (div_start),
    .word      (word),
    .dividend  (word ? {gpr[rp_hi], gpr[rp_lo]} : {16'h0000, dst}),
    .divisor   (word ? src : {8'h00, src[7:0]}),
    .done      (div_done),
    .quotient  (quo),
    .remainder (rem),
    .overflow  (div_ovf)
  );

  // Flags not named in a branch stay as they were
  always_comb begin
    next_gpr   = gpr;
    next_flags = flags;
    next_state = state;
    next_idx   = idx;
    mem_we     = 1'b0;
    mem_wa     = ea[7:1];
    mem_wd     = store_wd;
    case (state)
      ST_IDLE: begin
        if (wr_reg) begin
          next_gpr[a_addr[4:2]] = hwdata[15:0];
        end
        if (wr_flags) begin
          next_flags = hwdata[3:0];
        end
        if (wr_mem) begin
          mem_we = 1'b1;
          mem_wa = a_addr[8:2];
          mem_wd = hwdata[15:0];
        end
        if (wr_cmd) begin
          next_state = ST_RUN;
          next_idx   = (hwdata[CMD_OP_LSB +: 5] == OP_MULTI_REGISTER_STORE) ? 3'h7 : 3'h0;
        end
      end
      ST_RUN: begin
        next_state = ST_IDLE;
        case (op)
          OP_LOAD_ABS, OP_LOAD_FP: begin
            next_gpr[rd] = merge(dst, mdata, word);
            next_flags   = {nz(mdata, word), 1'b0, flags[FLG_C]};
          end
          OP_STORE_ABS, OP_STORE_FP: begin
            mem_we     = 1'b1;
            next_flags = {nz(dst, word), 1'b0, flags[FLG_C]};
          end
          OP_MULTI_REGISTER_STORE, OP_MULTI_REGISTER_LOAD: begin
            next_state = ST_MULTI;
          end
          OP_SWAP: begin
            next_gpr[rd] = swapped;
            next_flags   = {nz(swapped, 1'b1), 1'b0, flags[FLG_C]};
          end
          OP_REGISTER_EXCHANGE: begin
            next_gpr[rd] = gpr[rs];
            next_gpr[rs] = dst;
          end
          OP_ECLK_SYNC_WRITE, OP_ECLK_SYNC_READ: begin
            next_state = ST_ECLK;
          end
          OP_ADD_QUICK: begin
            next_gpr[rd] = alu_quick[15:0];
            next_flags   = alu_quick[19:16];
          end
          OP_FLAG_PRESERVING_ADD: begin
            next_gpr[rd] = dst + src_sx;
          end
          OP_FLAG_PRESERVING_SUBTRACT: begin
            next_gpr[rd] = dst - src_sx;
          end
          OP_ADD_WITH_CARRY: begin
            next_gpr[rd] = alu_add[15:0];
            next_flags   = alu_add[19:16];
          end
          OP_SUBTRACT_WITH_BORROW: begin
            next_gpr[rd] = alu_sub[15:0];
            next_flags   = alu_sub[19:16];
          end
          OP_DECIMAL_ADD: begin
            next_gpr[rd] = {dst[15:8], bcd_sum[7:0]};
            next_flags   = {flags[FLG_N], bcd_sum[7:0] == 8'h00, flags[FLG_V], bcd_sum[8]};
          end
          OP_DECIMAL_SUBTRACT: begin
            next_gpr[rd] = {dst[15:8], bcd_diff[7:0]};
            next_flags   = {flags[FLG_N], bcd_diff[7:0] == 8'h00, flags[FLG_V], bcd_diff[8]};
          end
          OP_UNSIGNED_MULTIPLY: begin
            if (word) begin
              next_gpr[rp_hi] = prod_w[31:16];
              next_gpr[rp_lo] = prod_w[15:0];
              next_flags      = {prod_w[31], prod_w == 32'h00000000, 2'b00};
            end else begin
              next_gpr[rd] = prod_b;
              next_flags   = {nz(prod_b, 1'b1), 2'b00};
            end
          end
          OP_UNSIGNED_DIVIDE: begin
            next_state = ST_DIV;
          end
          OP_COMPARE_OP: begin
            next_flags = alu_cmp[19:16];
          end
          default: begin
            next_state = ST_IDLE;
          end
        endcase
      end
      // One listed register per cycle; unlisted ones cost a cycle too
      ST_MULTI: begin
        if (op == OP_MULTI_REGISTER_STORE) begin
          if (opnd[idx]) begin
            next_gpr[REG_SP] = sp_dec;
            mem_we           = 1'b1;
            mem_wa           = sp_dec[7:1];
            mem_wd           = gpr[idx];
          end
          next_idx   = idx - 3'h1;
          next_state = (idx == 3'h0) ? ST_IDLE : ST_MULTI;
        end else begin
          if (opnd[idx]) begin
            next_gpr[idx]    = mem[sp[7:1]];
            next_gpr[REG_SP] = sp_inc;
          end
          next_idx   = idx + 3'h1;
          next_state = (idx == 3'h7) ? ST_IDLE : ST_MULTI;
        end
      end
      // Transfer lands at the end of the E high phase
      ST_ECLK: begin
        if (e_fall) begin
          next_state = ST_IDLE;
          if (op == OP_ECLK_SYNC_WRITE) begin
            mem_we = 1'b1;
          end else begin
            next_gpr[rd] = merge(dst, mdata, word);
          end
        end
      end
      ST_DIV: begin
        if (div_done) begin
          next_state = ST_IDLE;
          if (div_ovf) begin
            next_flags = 4'b0010;
          end else if (word) begin
            next_gpr[rp_hi] = rem;
            next_gpr[rp_lo] = quo;
            next_flags      = {nz(quo, 1'b1), 2'b00};
          end else begin
            next_gpr[rd] = {rem[7:0], quo[7:0]};
            next_flags   = {nz(quo, 1'b0), 2'b00};
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      a_valid   <= 1'b0;
      a_write   <= 1'b0;
      a_addr    <= 12'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      a_valid   <= acc;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (acc) begin
        a_write <= hwrite;
        a_addr  <= ra;
        hrdata  <= hwrite ? 32'h00000000 : rd_word;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      op      <= OP_NOP;
      word    <= 1'b0;
      rd      <= 3'h0;
      rs      <= 3'h0;
      imm_sel <= 1'b0;
      opnd    <= 16'h0000;
    end else begin
      if (wr_cmd) begin
        op      <= op_t'(hwdata[CMD_OP_LSB +: 5]);
        word    <= hwdata[CMD_WORD_BIT];
        rd      <= hwdata[CMD_RD_LSB +: 3];
        rs      <= hwdata[CMD_RS_LSB +: 3];
        imm_sel <= hwdata[CMD_IMM_BIT];
      end
      if (wr_opnd) begin
        opnd <= hwdata[15:0];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      idx   <= 3'h0;
      flags <= FLAGS_RESET;
      busy  <= 1'b0;
    end else begin
      state <= next_state;
      idx   <= next_idx;
      flags <= next_flags;
      busy  <= next_state != ST_IDLE;
    end
  end

  for (genvar g = 0; g < 8; g++) begin : g_gpr
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        gpr[g] <= GPR_RESET;
      end else begin
        gpr[g] <= next_gpr[g];
      end
    end
  end

  // No reset on the data memory; software preloads it
  always_ff @(posedge clock) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Free-running E clock, high and low for ECLK_HALF cycles each
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      e_cnt <= 4'h0;
      eclk  <= 1'b0;
    end else if (e_cnt == ECLK_HALF - 4'h1) begin
      e_cnt <= 4'h0;
      eclk  <= !eclk;
    end else begin
      e_cnt <= e_cnt + 4'h1;
    end
  end

endmodule : dp_core

// >>> src/dp_divider.sv
// Sequential restoring divider, 32 by 16 bits, one quotient bit a cycle.
// Assumes start is a one-cycle pulse and operands are steady with it.
`timescale 1ns/1ns
module dp_divider
  import dp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        start,
  input  wire logic        word,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  output logic             done,
  output logic [15:0]      quotient,
  output logic [15:0]      remainder,
  output logic             overflow
);

  logic [15:0] dvs;
  logic [4:0]  cnt;
  logic        running;
  logic [16:0] trial;
  logic        fits;
  logic        ovf_now;

  // Quotient would not fit the destination size
  assign ovf_now = (divisor == 16'h0000) ||
                   (word ? (dividend[31:16] >= divisor)
                         : (dividend[15:8] >= divisor[7:0]));
  assign trial = {remainder, quotient[15]};
  assign fits  = trial >= {1'b0, dvs};

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      done      <= 1'b0;
      quotient  <= 16'h0000;
      remainder <= 16'h0000;
      overflow  <= 1'b0;
      dvs       <= 16'h0000;
      cnt       <= 5'h00;
      running   <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        overflow  <= ovf_now;
        dvs       <= divisor;
        remainder <= dividend[31:16];
        quotient  <= dividend[15:0];
        cnt       <= DIV_STEPS;
        running   <= !ovf_now;
        done      <= ovf_now;
      end else if (running) begin
        remainder <= fits ? 16'(trial - {1'b0, dvs}) : trial[15:0];
        quotient  <= {quotient[14:0], fits};
        cnt       <= cnt - 5'h01;
        running   <= cnt != 5'h01;
        done      <= cnt == 5'h01;
      end
    end
  end

endmodule : dp_divider

// >>> src/dp_pkg.sv
// Shared constants for the move and arithmetic datapath.
// Assumes one AHB-Lite slave with whole-word register access.
package dp_pkg;

  // Register map, byte addresses
  localparam logic [11:0] OFF_CMD   = 12'h000;
  localparam logic [11:0] OFF_OPND  = 12'h004;
  localparam logic [11:0] OFF_FLAGS = 12'h008;
  localparam logic [11:0] OFF_STAT  = 12'h00c;
  localparam logic [11:0] OFF_REG   = 12'h040;
  localparam logic [11:0] OFF_MEM   = 12'h200;

  // Command register fields
  localparam int CMD_OP_LSB  = 0;
  localparam int CMD_WORD_BIT = 5;
  localparam int CMD_RD_LSB  = 6;
  localparam int CMD_RS_LSB  = 9;
  localparam int CMD_IMM_BIT = 12;

  // Condition flag positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;

  // Reset values
  localparam logic [3:0]  FLAGS_RESET = 4'h0;
  localparam logic [15:0] GPR_RESET   = 16'h0000;

  localparam logic [2:0] REG_FP = 3'h6;
  localparam logic [2:0] REG_SP = 3'h7;
  localparam int         MEM_WORDS = 128;

  // Timing counts in clock cycles
  localparam logic [3:0] ECLK_HALF = 4'h4;
  localparam logic [4:0] DIV_STEPS = 5'h10;

  typedef enum logic [4:0] {
    OP_NOP, OP_LOAD_ABS, OP_STORE_ABS, OP_LOAD_FP, OP_STORE_FP,
    OP_MULTI_REGISTER_STORE, OP_MULTI_REGISTER_LOAD, OP_SWAP,
    OP_REGISTER_EXCHANGE, OP_ECLK_SYNC_WRITE, OP_ECLK_SYNC_READ,
    OP_ADD_QUICK, OP_FLAG_PRESERVING_ADD, OP_FLAG_PRESERVING_SUBTRACT,
    OP_ADD_WITH_CARRY, OP_SUBTRACT_WITH_BORROW, OP_DECIMAL_ADD,
    OP_DECIMAL_SUBTRACT, OP_UNSIGNED_MULTIPLY, OP_UNSIGNED_DIVIDE,
    OP_COMPARE_OP
  } op_t;

endpackage : dp_pkg

// >>> verif/dp_core_properties.sv
// Port checker for dp_core: command timing, E clock and bus answers.
// Assumes hready is the slave's own hreadyout, as on a one-slave bus.
`timescale 1ns/1ns
module dp_core_properties
  import dp_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic        eclk,
  input wire logic        busy
);
  logic       cmd_dp;
  logic       go;
  logic [4:0] cop;
  // Command data phase: the op code stands on hwdata here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) cmd_dp <= 1'b0;
    else cmd_dp <= hsel && htrans[1] && hready && hwrite && haddr[11:0] == OFF_CMD;
  end
  assign go  = cmd_dp && !busy;
  assign cop = hwdata[4:0];
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  cmd_start_a: assert property (go && cop != 5'h00 |=> busy)
    else $error("busy did not rise after a command");
  single_op_a: assert property (go && cop inside {[5'h01:5'h04], [5'h07:5'h08],
    [5'h0b:5'h12], 5'h14} |=> busy ##1 !busy)
    else $error("single op did not finish in one cycle");
  multi_op_a: assert property (go && cop inside {5'h05, 5'h06} |=>
    busy [*8] ##1 busy ##1 !busy)
    else $error("multi register op length wrong");
  eclk_op_a: assert property (go && cop inside {5'h09, 5'h0a} |=> busy ##[1:9] !busy)
    else $error("E synchronised op too long");
  divide_op_a: assert property (go && cop == 5'h13 |=> busy ##[1:18] !busy)
    else $error("divide too long");
  eclk_high_a: assert property ($rose(eclk) |-> eclk [*4] ##1 !eclk)
    else $error("E clock high phase wrong");
  eclk_low_a: assert property ($fell(eclk) |-> !eclk [*4] ##1 eclk)
    else $error("E clock low phase wrong");
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready and okay");
endmodule : dp_core_properties

bind dp_core dp_core_properties i_dp_core_properties (.clock, .rst_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .eclk, .busy);

// >>> verif/dp_core_tb.sv
// Bench for dp_core: bus tasks, a reference model and op sweeps.
// Assumes the zero-wait slave; hready is fed back from hreadyout.
`timescale 1ns/1ns
module dp_core_tb
  import dp_pkg::*;
;
  logic        clock;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hready;
  logic        hreadyout;
  logic [31:0] hrdata;
  logic        hresp;
  logic        eclk;
  logic        busy;
  logic [15:0] a, b, er, q, y, r;
  logic [7:0]  ad;
  logic [3:0]  f, ef;
  logic        v;
  int          failures, n_tests, seed, t, da, db, m, w, op;
  int          ops[12] = '{7, 8, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20};
  int          st[3] = '{2, 4, 9};
  int          ld[3] = '{1, 3, 10};

  assign hready = hreadyout;
  dp_core i_dp_core (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
                     .hready, .hreadyout, .hrdata, .hresp, .eclk, .busy);

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic xfer(input logic wr_en, input logic [11:0] ad_in, input logic [15:0] d,
                      output logic [31:0] x);
    haddr  <= {20'h00000, ad_in};
    htrans <= 2'h2;
    hwrite <= wr_en;
    do @(posedge clock); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {16'h0000, d};
    do @(posedge clock); while (hready !== 1'b1);
    x = hrdata;
  endtask : xfer

  task automatic wr(input logic [11:0] ad_in, input logic [15:0] d);
    logic [31:0] x;
    xfer(1'b1, ad_in, d, x);
  endtask : wr

  task automatic chk(input logic [11:0] ad_in, input logic [15:0] e);
    logic [31:0] x;
    xfer(1'b0, ad_in, 16'h0000, x);
    n_tests++;
    if (x !== {16'h0000, e}) begin
      failures++;
      $display("[FAIL] %0t read %h got %h exp %h", $time, ad_in, x, e);
    end
  endtask : chk

  // Every command uses R1 as rd and R2 as rs
  task automatic run(input int o, input int wd, input logic [15:0] p);
    logic [31:0] x;
    wr(OFF_OPND, p);
    wr(OFF_CMD, 16'(o + wd * 16'h1020 + 16'h0440));
    x = 32'h1;
    for (int i = 0; i < 40 && x[0] !== 1'b0; i++) xfer(1'b0, OFF_STAT, 16'h0000, x);
    if (x[0] !== 1'b0) begin
      failures++;
      $display("[FAIL] %0t command %0d never finished", $time, o);
    end
  endtask : run

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : test_done

  initial begin
    #2000000;
    failures++;
    test_done;
  end

  initial begin
    seed = 94675;
    failures = 0;
    n_tests = 0;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    chk(OFF_FLAGS, {12'h000, FLAGS_RESET});
    chk(OFF_REG + 12'h00c, GPR_RESET);
    wr(OFF_STAT, 16'hffff);
    chk(OFF_STAT, 16'h0000);
    chk(12'h100, 16'h0000);
    $display("test reset done");
    foreach (ops[j]) for (w = 0; w < 2; w++) begin
      op = ops[j];
      a = 16'($random(seed));
      b = op == 19 && w == 1 ? 16'h0000 : 16'($random(seed));
      f = 4'($random(seed));
      da = {$random(seed)} % 100;
      db = {$random(seed)} % 100;
      // Byte divide kept in range, word divide by zero overflows
      if (op == 19 && w == 0) begin
        a[15] = 1'b0;
        b[7]  = 1'b1;
      end
      if (op inside {16, 17}) begin
        a[7:0] = 8'(da / 10 * 16 + da % 10);
        b[7:0] = 8'(db / 10 * 16 + db % 10);
      end
      m = w ? 16 : 8;
      q = w ? 16'hffff : 16'h00ff;
      er = a;
      ef = f;
      case (op)
        7: begin
          er = {a[7:0], a[15:8]};
          ef = {er[15], er == 16'h0, 1'b0, f[0]};
        end
        8: er = b;
        12: er = a + (w ? b : {{8{b[7]}}, b[7:0]});
        13: er = a - (w ? b : {{8{b[7]}}, b[7:0]});
        16, 17: begin
          t = op == 16 ? da + db + f[0] : da - db - f[0];
          da = (t + 100) % 100;
          er[7:0] = 8'(da / 10 * 16 + da % 10);
          ef = {f[3], da == 0, f[1], t > 99 || t < 0};
        end
        18: begin
          t = w ? a * b : a[7:0] * b[7:0];
          er = 16'(t);
          ef = {1'(t >> (2 * m - 1)), t == 0, 2'h0};
        end
        19: if (w == 0) begin
          y = 16'(a / b[7:0]);
          er = {8'(a % b[7:0]), y[7:0]};
          ef = {y[7], y == 16'h0, 2'h0};
        end else begin
          ef = 4'h2;
        end
        default: begin
          y = op == 11 ? (b[1] ? q - b[0] : 16'h1 + b[0]) : b & q;
          v = (op == 14 || op == 15) && f[0];
          t = op inside {15, 20} ? (a & q) - y - v : (a & q) + y + v;
          r = 16'(t) & q;
          v = 1'((op inside {15, 20} ? (a ^ y) & (a ^ r) : ~(a ^ y) & (a ^ r)) >> (m - 1));
          er = op == 20 ? a : (a & ~q) | r;
          ef = {r[m - 1], r == 16'h0, v, 1'(t >>> m)};
        end
      endcase
      wr(OFF_REG + 12'h004, a);
      wr(OFF_REG + 12'h008, b);
      wr(OFF_FLAGS, {12'h000, f});
      run(op, w, b);
      chk(OFF_REG + 12'h004, er);
      chk(OFF_FLAGS, {12'h000, ef});
      if (op == 8) chk(OFF_REG + 12'h008, a);
      if (op == 18 && w == 1) chk(OFF_REG, 16'(t >> 16));
    end
    $display("test arithmetic done");
    wr(OFF_REG + 12'h018, 16'h0010);
    for (int j = 0; j < 3; j++) begin
      a = 16'($random(seed));
      f = 4'($random(seed));
      ad = 8'({$random(seed)} % 128 * 2);
      wr(OFF_REG + 12'h004, a);
      wr(OFF_FLAGS, {12'h000, f});
      run(st[j], 1, {8'h00, (j == 1 ? ad - 8'h10 : ad)});
      chk(OFF_MEM + {3'h0, ad[7:1], 2'h0}, a);
      wr(OFF_REG + 12'h004, ~a);
      run(ld[j], 1, {8'h00, (j == 1 ? ad - 8'h10 : ad)});
      chk(OFF_REG + 12'h004, a);
      chk(OFF_FLAGS, {12'h000, (j == 2 ? f : {a[15], a == 16'h0, 1'b0, f[0]})});
    end
    $display("test moves done");
    a = 16'($random(seed));
    b = 16'($random(seed));
    wr(OFF_REG + 12'h01c, 16'h0080);
    wr(OFF_REG + 12'h004, a);
    wr(OFF_REG + 12'h008, b);
    run(5, 1, 16'h0006);
    chk(OFF_REG + 12'h01c, 16'h007c);
    chk(OFF_MEM + 12'h0f8, a);
    wr(OFF_REG + 12'h004, 16'h0000);
    wr(OFF_REG + 12'h008, 16'h0000);
    run(6, 1, 16'h0006);
    chk(OFF_REG + 12'h004, a);
    chk(OFF_REG + 12'h008, b);
    chk(OFF_REG + 12'h01c, 16'h0080);
    chk(OFF_FLAGS, {12'h000, f});
    $display("test multi register done");
    test_done;
  end
endmodule : dp_core_tb
